// file: tfba_map.vh
// Constants for the transparent file byte access block
`ifndef TFBA_MAP_VH
`define TFBA_MAP_VH

// Command operation codes
`define TFBA_OP_SELECT  2'h0
`define TFBA_OP_VERIFY  2'h1
`define TFBA_OP_READ    2'h2
`define TFBA_OP_UPDATE  2'h3

// Status word bytes
`define TFBA_SW_OK1     8'h90
`define TFBA_SW_OK2     8'h00
`define TFBA_SW_SEC1    8'h69
`define TFBA_SW_SEC2    8'h82
`define TFBA_SW_STR1    8'h69
`define TFBA_SW_STR2    8'h81
`define TFBA_SW_RNG1    8'h6b
`define TFBA_SW_RNG2    8'h00
`define TFBA_SW_NOF1    8'h6a
`define TFBA_SW_NOF2    8'h82
`define TFBA_SW_PIN1    8'h63
`define TFBA_SW_PIN2    8'hc0

// PIN value compared on verify, arbitrary
`define TFBA_PIN        15'h1234

// File table: size, transparent flag, PIN protection, short identifier
`define TFBA_SIZE0      5'h0b
`define TFBA_SIZE1      5'h10
`define TFBA_SIZE2      5'h10
`define TFBA_SIZE3      5'h10
`define TFBA_TRANSP     4'h3
`define TFBA_PROT       4'h9
`define TFBA_SFI0       5'h01
`define TFBA_SFI1       5'h02

// Storage geometry and response buffer
`define TFBA_FILE_BYTES 16
`define TFBA_FIFO_DEPTH 16

`endif

// file: tfba_fifo.v
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module tfba_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire         clk_in,
  input  wire         rst_in,
  input  wire         in_valid_in,
  input  wire [W-1:0] in_data_in,
  output wire         in_ready_out,
  output wire         out_valid_out,
  output wire [W-1:0] out_data_out,
  input  wire         out_ready_in
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0]   count;
  wire         push;
  wire         pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_out  = (count != D[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out  = mem[rptr];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Storage is not reset; only the pointers and the count carry state
  always @(posedge clk_in)
  begin
    if (push)
      mem[wptr] <= in_data_in;
  end

  // Pointer and count update
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wptr <= wptr + 1'b1;
      if (pop)
        rptr <= rptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end
endmodule // tfba_fifo

// file: tfba_core.v
// Binary read and update command engine for transparent files
// How it works
// - Read returns consecutive bytes from the current transparent file.
// - Read offset and count select which bytes come back.
// - Requested bytes go out as response data on success.
// - Read without access returns no data and status 69 82.
// - Successful PIN verify opens protected files for read and update.
// - Normal completion of read or update ends with status 90 00.
// - Read at offset 1 of 10 bytes starts at the second byte.
// - Both commands accept a short identifier instead of prior selection.
// - Update by short identifier makes that file the current one.
// - Commands on non-transparent files abort with status 69 81.
// - Update overwrites bytes of the current transparent file.
// - Update writes exactly count bytes starting at offset.
// - Update without access leaves data unchanged, status 69 82.
// - One-byte update at offset 1 changes only the second byte.
`timescale 1ns/1ps
`include "tfba_map.vh"
module tfba_core (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        cmd_valid_in,
  output wire        cmd_ready_out,
  input  wire [1:0]  cmd_op_in,
  input  wire [1:0]  cmd_file_in,
  input  wire [4:0]  cmd_sfi_in,
  input  wire [14:0] cmd_offset_in,
  input  wire [7:0]  cmd_len_in,
  input  wire        wr_valid_in,
  input  wire [7:0]  wr_data_in,
  output wire        wr_ready_out,
  output wire        rsp_valid_out,
  output wire [7:0]  rsp_data_out,
  input  wire        rsp_ready_in,
  output reg         sw_valid_out,
  output reg  [7:0]  sw1_out,
  output reg  [7:0]  sw2_out,
  output reg         pin_ok_out,
  output reg  [1:0]  cur_file_out
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_CHECK  = 3'h1;
  localparam ST_READ   = 3'h2;
  localparam ST_WRITE  = 3'h3;
  localparam ST_DRAIN  = 3'h4;
  localparam ST_STATUS = 3'h5;

  // File attribute bit maps, one bit per file index; a macro literal cannot be indexed
  localparam [3:0] TRANSP_MAP = `TFBA_TRANSP;
  localparam [3:0] PROT_MAP   = `TFBA_PROT;

  reg  [7:0]  mem [0:4*`TFBA_FILE_BYTES-1];
  reg  [2:0]  state;
  reg  [1:0]  op;
  reg  [1:0]  sel_file;
  reg  [4:0]  sfi;
  reg  [14:0] offset;
  reg  [7:0]  len;
  reg  [1:0]  tgt;
  reg  [3:0]  ptr;
  reg  [7:0]  cnt;
  wire        fifo_ready;
  wire        fifo_push;
  wire        sfi_hit;
  wire [1:0]  sfi_file;
  wire [1:0]  file;
  wire [15:0] end_pos;
  wire [5:0]  addr;
  wire        take;
  wire [2:0]  sfi_dec;
  wire        bad_sfi;
  wire        not_transp;
  wire        locked;
  wire        out_of_range;
  wire        refuse;

  ////////////////////////////////////////////////////////////////////////
  // File table lookups

  // Short identifier to file index; bit 2 flags a known identifier
  function [2:0] tfba_sfi_decode;
    input [4:0] id;
    begin
      if (id == `TFBA_SFI0)
        tfba_sfi_decode = 3'h4;
      else if (id == `TFBA_SFI1)
        tfba_sfi_decode = 3'h5;
      else
        tfba_sfi_decode = 3'h0;
    end
  endfunction

  // File size in bytes
  function [4:0] tfba_size;
    input [1:0] f;
    begin
      case (f)
        2'h0:    tfba_size = `TFBA_SIZE0;
        2'h1:    tfba_size = `TFBA_SIZE1;
        2'h2:    tfba_size = `TFBA_SIZE2;
        default: tfba_size = `TFBA_SIZE3;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Target file and bounds

  // short identifier overrides the current file
  assign sfi_dec  = tfba_sfi_decode(sfi);
  assign sfi_hit  = sfi_dec[2];
  assign sfi_file = sfi_dec[1:0];
  assign file     = (sfi != 5'h00) ? sfi_file : cur_file_out;
  // end position kept wide so large offsets cannot wrap
  assign end_pos  = {1'b0, offset} + {8'h00, len};
  // byte address is file base plus running offset
  assign addr     = {tgt, ptr};

  ////////////////////////////////////////////////////////////////////////
  // Refusal conditions, in the order the status word reports them

  // an unknown short identifier names no file
  assign bad_sfi      = (sfi != 5'h00) && !sfi_hit;
  // only transparent files take byte commands
  assign not_transp   = !TRANSP_MAP[file];
  // protected files wait for a verified PIN
  assign locked       = PROT_MAP[file] && !pin_ok_out;
  // a request must end inside the file
  assign out_of_range = end_pos > {11'h000, tfba_size(file)};
  // Any refusal; a refused update still drains so the byte stream stays aligned
  assign refuse       = bad_sfi | not_transp | locked | out_of_range;

  ////////////////////////////////////////////////////////////////////////
  // Handshakes

  assign cmd_ready_out = (state == ST_IDLE);
  assign wr_ready_out  = (state == ST_WRITE) || (state == ST_DRAIN);
  assign take          = wr_valid_in & wr_ready_out;
  // read bytes enter the response buffer, stalling when full
  assign fifo_push     = (state == ST_READ);

  // response byte comes from the target file at the pointer
  tfba_fifo #(
    .W  (8),
    .D  (`TFBA_FIFO_DEPTH),
    .AW (4)
  ) u_rsp_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (fifo_push),
    .in_data_in    (mem[addr]),
    .in_ready_out  (fifo_ready),
    .out_valid_out (rsp_valid_out),
    .out_data_out  (rsp_data_out),
    .out_ready_in  (rsp_ready_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // File storage

  // update overwrites bytes; refused updates never reach here
  always @(posedge clk_in)
  begin
    if ((state == ST_WRITE) && wr_valid_in)
      mem[addr] <= wr_data_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state        <= ST_IDLE;
      op           <= 2'h0;
      sel_file     <= 2'h0;
      sfi          <= 5'h00;
      offset       <= 15'h0000;
      len          <= 8'h00;
      tgt          <= 2'h0;
      ptr          <= 4'h0;
      cnt          <= 8'h00;
      sw_valid_out <= 1'b0;
      sw1_out      <= 8'h00;
      sw2_out      <= 8'h00;
      // any reset drops the verified state
      pin_ok_out   <= 1'b0;
      cur_file_out <= 2'h0;
    end
    else
    begin
      sw_valid_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (cmd_valid_in)
          begin
            op       <= cmd_op_in;
            sel_file <= cmd_file_in;
            sfi      <= cmd_sfi_in;
            offset   <= cmd_offset_in;
            len      <= cmd_len_in;
            state    <= ST_CHECK;
          end
        end
        ST_CHECK:
        begin
          tgt   <= file;
          ptr   <= offset[3:0];
          cnt   <= len;
          state <= ST_STATUS;
          sw1_out <= `TFBA_SW_OK1;
          sw2_out <= `TFBA_SW_OK2;
          if (op == `TFBA_OP_SELECT)
            cur_file_out <= sel_file;
          else if (op == `TFBA_OP_VERIFY)
          begin
            if (offset == `TFBA_PIN)
              pin_ok_out <= 1'b1;
            else
            begin
              sw1_out <= `TFBA_SW_PIN1;
              sw2_out <= `TFBA_SW_PIN2;
            end
          end
          else
          begin
            if (bad_sfi)
            begin
              sw1_out <= `TFBA_SW_NOF1;
              sw2_out <= `TFBA_SW_NOF2;
            end
            else if (not_transp)
            begin
              sw1_out <= `TFBA_SW_STR1;
              sw2_out <= `TFBA_SW_STR2;
            end
            else if (locked)
            begin
              sw1_out <= `TFBA_SW_SEC1;
              sw2_out <= `TFBA_SW_SEC2;
            end
            // request beyond the end of file
            else if (out_of_range)
            begin
              sw1_out <= `TFBA_SW_RNG1;
              sw2_out <= `TFBA_SW_RNG2;
            end
            else
            begin
              // short identifier selects the file as current
              if (sfi != 5'h00)
                cur_file_out <= file;
              if (len != 8'h00)
                state <= (op == `TFBA_OP_READ) ? ST_READ : ST_WRITE;
            end
            // Refused update still swallows its data bytes
            if (op == `TFBA_OP_UPDATE && len != 8'h00)
            begin
              if (refuse)
                state <= ST_DRAIN;
            end
          end
        end
        ST_READ:
        begin
          // pointer starts at the offset and walks forward
          if (fifo_ready)
          begin
            ptr <= ptr + 4'h1;
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01)
              state <= ST_STATUS;
          end
        end
        ST_WRITE,
        ST_DRAIN:
        begin
          // exactly count bytes from the offset
          if (take)
          begin
            ptr <= ptr + 4'h1;
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01)
              state <= ST_STATUS;
          end
        end
        ST_STATUS:
        begin
          sw_valid_out <= 1'b1;
          state        <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule // tfba_core

// file: tfba_core_assertions.sv
// Port checks for the binary read and update engine
`timescale 1ns/1ps
module tfba_core_chk (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       cmd_valid_in,
  input wire logic       cmd_ready_out,
  input wire logic [1:0] cmd_op_in,
  input wire logic [4:0] cmd_sfi_in,
  input wire logic [7:0] cmd_len_in,
  input wire logic       wr_ready_out,
  input wire logic       rsp_valid_out,
  input wire logic       sw_valid_out,
  input wire logic [7:0] sw1_out,
  input wire logic [7:0] sw2_out,
  input wire logic       pin_ok_out,
  input wire logic [1:0] cur_file_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  // A take, and a plain read of the locked file with the buffer empty
  sequence s_take;
    cmd_valid_in && cmd_ready_out;
  endsequence
  sequence s_locked_rd;
    s_take ##0 (cmd_op_in == 2'h2 && cmd_sfi_in == 5'h00 && cur_file_out == 2'h0
      && !pin_ok_out && !rsp_valid_out);
  endsequence
  // An update that carries data bytes
  sequence s_upd;
    s_take ##0 (cmd_op_in == 2'h3 && cmd_len_in != 8'h00);
  endsequence
  ////////////////////////////////////////
  chk_status_gap: assert property (s_take |=> !sw_valid_out [*2])
    else $error("status too soon");
  chk_status_due: assert property (s_take |-> ##[3:60] sw_valid_out)
    else $error("status missing");
  chk_locked_read: assert property (s_locked_rd |=> !rsp_valid_out [*4])
    else $error("locked read gave data");
  chk_locked_sw: assert property (
    sw_valid_out && sw1_out == 8'h69 && sw2_out == 8'h82 |-> !pin_ok_out)
    else $error("refusal while open");
  chk_struct_file: assert property (
    sw_valid_out && sw1_out == 8'h69 && sw2_out == 8'h81 |-> cur_file_out[1])
    else $error("structure refusal on a flat file");
  chk_pin_hold: assert property (pin_ok_out |=> pin_ok_out)
    else $error("access lost without reset");
  chk_rsp_busy: assert property ($rose(rsp_valid_out) |-> !cmd_ready_out)
    else $error("data outside a read");
  chk_wr_busy: assert property (wr_ready_out |-> !cmd_ready_out)
    else $error("write ready while idle");
  chk_wr_open: assert property (s_upd |-> ##2 wr_ready_out)
    else $error("update bytes not accepted");
endmodule // tfba_core_chk
bind tfba_core tfba_core_chk chk (.clk_in, .rst_in, .cmd_valid_in, .cmd_ready_out, .cmd_op_in,
  .cmd_sfi_in, .cmd_len_in, .wr_ready_out, .rsp_valid_out, .sw_valid_out, .sw1_out, .sw2_out,
  .pin_ok_out, .cur_file_out);

// file: tfba_term_model.sv
// Terminal side reader that collects response bytes and can stall
`timescale 1ns/1ps
module tfba_term_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       stall_in,
  input  wire logic       rsp_valid_in,
  input  wire logic [7:0] rsp_data_in,
  output logic            rsp_ready_out
);
  logic [7:0] q [$];
  // ready lags the stall by one edge, like a slow reader
  always @(posedge clk_in or posedge rst_in)
    if (rst_in)
      rsp_ready_out <= 1'b0;
    else
    begin
      rsp_ready_out <= !stall_in;
      if (rsp_valid_in && rsp_ready_out)
        q.push_back(rsp_data_in);
    end
endmodule // tfba_term_model

// file: transparent_file_byte_access_tb.sv
// Self-checking bench for the binary read and update engine
`timescale 1ns/1ps
`include "tfba_map.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module transparent_file_byte_access_tb;
  logic        clk_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0, wr_valid_in = 1'b0;
  logic        stall = 1'b0;
  logic [1:0]  cmd_op_in = 2'h0, cmd_file_in = 2'h0, cur_file_out;
  logic [4:0]  cmd_sfi_in = 5'h00;
  logic [14:0] cmd_offset_in = 15'h0000;
  logic [7:0]  cmd_len_in = 8'h00, wr_data_in = 8'h00, rsp_data_out, sw1_out, sw2_out;
  logic        cmd_ready_out, wr_ready_out, rsp_valid_out, rsp_ready_in, sw_valid_out;
  logic        pin_ok_out;
  logic [7:0]  wbuf [16];
  logic [7:0]  img [2][16];
  int          miscompares = 0;
  int          n_compared = 0;
  // 20 MHz clock
  always #25 clk_in = ~clk_in;
  tfba_core dut (.clk_in, .rst_in, .cmd_valid_in, .cmd_ready_out, .cmd_op_in, .cmd_file_in,
    .cmd_sfi_in, .cmd_offset_in, .cmd_len_in, .wr_valid_in, .wr_data_in, .wr_ready_out,
    .rsp_valid_out, .rsp_data_out, .rsp_ready_in, .sw_valid_out, .sw1_out, .sw2_out,
    .pin_ok_out, .cur_file_out);
  tfba_term_model term (.clk_in, .rst_in, .stall_in(stall), .rsp_valid_in(rsp_valid_out),
    .rsp_data_in(rsp_data_out), .rsp_ready_out(rsp_ready_in));
  ////////////////////////////////////////
  // One command; update bytes are fed from wbuf even when refused
  task automatic cmd(input logic [1:0] op, f, input logic [4:0] sfi,
    input logic [14:0] off, input logic [7:0] len, e1, e2);
    int   i;
    logic tk;
    begin
      i = 0;
      @(posedge clk_in);
      cmd_op_in     <= op;
      cmd_file_in   <= f;
      cmd_sfi_in    <= sfi;
      cmd_offset_in <= off;
      cmd_len_in    <= len;
      cmd_valid_in  <= 1'b1;
      wr_valid_in   <= op == 2'h3 && len != 8'h00;
      wr_data_in    <= wbuf[0];
      do @(negedge clk_in); while (!cmd_ready_out);
      @(posedge clk_in);
      cmd_valid_in <= 1'b0;
      for (int t = 0; t < 300; t++)
      begin
        @(negedge clk_in);
        if (sw_valid_out)
          break;
        tk = wr_valid_in && wr_ready_out;
        @(posedge clk_in);
        if (tk)
        begin
          i++;
          wr_valid_in <= i < len;
          wr_data_in  <= wbuf[i[3:0]];
        end
      end
      `CHK(sw_valid_out, 1'b1)
      `CHK({sw1_out, sw2_out}, {e1, e2})
    end
  endtask
  task automatic sel(input logic [1:0] f);
    cmd(2'h0, f, 5'h00, 15'h0000, 8'h00, 8'h90, 8'h00);
  endtask
  // Read, then compare every collected byte with the image
  task automatic rd(input int fi, input logic [4:0] sfi, input logic [14:0] off,
    input logic [7:0] len, e1, e2);
    int k;
    begin
      term.q.delete();
      cmd(2'h2, 2'h0, sfi, off, len, e1, e2);
      k = (e1 == 8'h90) ? len : 0;
      for (int t = 0; t < 60 && (t < 6 || term.q.size() < k); t++)
        @(negedge clk_in);
      `CHK(term.q.size(), k)
      foreach (term.q[j])
        `CHK(term.q[j], img[fi][off + j])
    end
  endtask
  task automatic up(input int fi, input logic [4:0] sfi, input logic [14:0] off,
    input logic [7:0] len, e1, e2);
    begin
      cmd(2'h3, 2'h0, sfi, off, len, e1, e2);
      if (e1 == 8'h90)
        for (int k = 0; k < len; k++)
          img[fi][off + k] = wbuf[k];
    end
  endtask
  task automatic pin;
    cmd(2'h1, 2'h0, 5'h00, `TFBA_PIN, 8'h00, 8'h90, 8'h00);
  endtask
  ////////////////////////////////////////
  task automatic t_access;
    begin
      for (int k = 0; k < 11; k++)
        wbuf[k] = (k < 9) ? 8'ha1 + k : 8'h00;
      sel(2'h0);
      rd(0, 5'h00, 15'h0000, 8'h0b, 8'h69, 8'h82);
      cmd(2'h1, 2'h0, 5'h00, `TFBA_PIN ^ 15'h0001, 8'h00, 8'h63, 8'hc0);
      `CHK(pin_ok_out, 1'b0)
      pin();
      `CHK(pin_ok_out, 1'b1)
      up(0, 5'h00, 15'h0000, 8'h0b, 8'h90, 8'h00);
      rd(0, 5'h00, 15'h0000, 8'h0b, 8'h90, 8'h00);
      rd(0, 5'h00, 15'h0000, 8'h01, 8'h90, 8'h00);
      rd(0, 5'h00, 15'h0001, 8'h0a, 8'h90, 8'h00);
      wbuf[0] = 8'he5;
      up(0, 5'h00, 15'h0001, 8'h01, 8'h90, 8'h00);
      rd(0, 5'h00, 15'h0000, 8'h0b, 8'h90, 8'h00);
      $display("access test done");
    end
  endtask
  // Short identifiers, structure and range refusals
  task automatic t_refer;
    begin
      sel(2'h1);
      wbuf[0] = 8'hd1;
      up(0, 5'h01, 15'h0000, 8'h01, 8'h90, 8'h00);
      `CHK(cur_file_out, 2'h0)
      rd(0, 5'h00, 15'h0000, 8'h0b, 8'h90, 8'h00);
      sel(2'h2);
      rd(0, 5'h01, 15'h0000, 8'h0b, 8'h90, 8'h00);
      for (int f = 2; f < 4; f++)
      begin
        sel(f[1:0]);
        rd(0, 5'h00, 15'h0000, 8'h01, 8'h69, 8'h81);
        up(0, 5'h00, 15'h0000, 8'h01, 8'h69, 8'h81);
      end
      rd(0, 5'h05, 15'h0000, 8'h01, 8'h6a, 8'h82);
      sel(2'h0);
      rd(0, 5'h00, 15'h000a, 8'h02, 8'h6b, 8'h00);
      up(0, 5'h00, 15'h000b, 8'h01, 8'h6b, 8'h00);
      rd(0, 5'h00, 15'h000a, 8'h01, 8'h90, 8'h00);
      $display("reference test done");
    end
  endtask
  // Fill the response buffer while the reader stalls
  task automatic t_fill;
    begin
      sel(2'h1);
      for (int k = 0; k < 16; k++)
        wbuf[k] = 8'h30 + k;
      up(1, 5'h00, 15'h0000, 8'h10, 8'h90, 8'h00);
      @(posedge clk_in);
      stall <= 1'b1;
      fork
        rd(1, 5'h00, 15'h0000, 8'h10, 8'h90, 8'h00);
        begin
          repeat (30) @(negedge clk_in);
          `CHK(rsp_valid_out, 1'b1)
          @(posedge clk_in);
          stall <= 1'b0;
        end
      join
      rd(1, 5'h00, 15'h0000, 8'h00, 8'h90, 8'h00);
      $display("fill test done");
    end
  endtask
  // Mid-run reset drops access; a refused update leaves data alone
  task automatic t_reset;
    begin
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      `CHK(pin_ok_out, 1'b0)
      for (int k = 0; k < 11; k++)
        wbuf[k] = 8'hff;
      up(0, 5'h00, 15'h0000, 8'h0b, 8'h69, 8'h82);
      pin();
      rd(0, 5'h00, 15'h0000, 8'h0b, 8'h90, 8'h00);
      $display("reset test done");
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    t_access();
    t_refer();
    t_fill();
    t_reset();
    print_verdict();
  end
  // Watchdog: the run needs well under a thousand cycles; this fires after 20000
  initial
  begin
    #1000000;
    miscompares++;
    print_verdict();
  end
endmodule // transparent_file_byte_access_tb
